//--- bench/csd_dma_channel_bench.sv
// self-checking bench of the codec slot dma channel
`timescale 1ns/1ns
`include "csd_defines.vh"
module csd_dma_channel_bench;
  localparam [31:0] A_C = {14'h0, `CSD_IDX_CTRL, 2'b00};
  localparam [31:0] A_H = {14'h0, `CSD_IDX_SSH, 2'b00};
  localparam [31:0] A_L = {14'h0, `CSD_IDX_SSL, 2'b00};
  localparam [31:0] A_S = {14'h0, `CSD_IDX_STAT, 2'b00};
  reg mclk_i = 0, rst_n_i = 0, slow = 0;
  reg [31:0] s_axi_awaddr_i = 0, s_axi_wdata_i = 0, s_axi_araddr_i = 0, cpi_rx_word_i = 32'h44332211;
  reg [3:0] s_axi_wstrb_i = 4'h1;
  reg s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  reg cpi_frame_start_i = 0, cpi_slot_tick_i = 0;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o, cpi_tx_word_o;
  wire [3:0] cpi_tx_slot_o;
  wire cpi_tx_we_o, ubm_req_o, ubm_ack_i, ubm_endpoint_direction_o, ubm_wrap_buffer_enable_o;
  wire [7:0] ubm_wdata_o, ubm_rdata_i, ubm_offset_o;
  wire [2:0] ubm_endpoint_select_o;
  integer err_count = 0, tests_run = 0, nb = 0, ntx = 0, b;
  reg [7:0] seen [0:63];
  reg [31:0] txw, rd_d;
  reg [3:0] txs;
  reg [1:0] rd_r, wr_r;
  csd_dma_channel csd_dma_channel_inst (.*);
  csd_ubm_model csd_ubm_model_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .slow_i(slow), .req_i(ubm_req_o),
    .offset_i(ubm_offset_o), .ack_o(ubm_ack_i), .rdata_o(ubm_rdata_i));
  initial forever #10 mclk_i = ~mclk_i;
  // collects bytes handed to the buffer and tx words
  always @(posedge mclk_i) begin
    if (ubm_req_o && ubm_ack_i) begin seen[nb[5:0]] = ubm_wdata_o; nb = nb + 1; end
    if (cpi_tx_we_o) begin ntx = ntx + 1; txw = cpi_tx_word_o; txs = cpi_tx_slot_o; end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin $display("Error %s expected %h seen %h", n, e, g); err_count = err_count + 1; end
  endtask
  task end_sim;
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input [31:0] a, input [7:0] d);
    @(posedge mclk_i);
    s_axi_awaddr_i <= a; s_axi_wdata_i <= {24'h0, d}; s_axi_awvalid_i <= 1; s_axi_wvalid_i <= 1; s_axi_bready_i <= 1;
    forever begin
      @(posedge mclk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 0;
      if (s_axi_bvalid_o) begin wr_r = s_axi_bresp_o; s_axi_bready_i <= 0; break; end
    end
  endtask
  task rd(input [31:0] a);
    @(posedge mclk_i);
    s_axi_araddr_i <= a; s_axi_arvalid_i <= 1; s_axi_rready_i <= 1;
    forever begin
      @(posedge mclk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 0;
      if (s_axi_rvalid_o) begin rd_d = s_axi_rdata_o; rd_r = s_axi_rresp_o; s_axi_rready_i <= 0; break; end
    end
  endtask
  task frame;
    integer s;
    nb = 0; ntx = 0;
    @(posedge mclk_i) cpi_frame_start_i <= 1;
    @(posedge mclk_i) cpi_frame_start_i <= 0;
    for (s = 1; s < 14; s = s + 1) begin
      repeat (23) @(posedge mclk_i);
      cpi_slot_tick_i <= 1;
      @(posedge mclk_i) cpi_slot_tick_i <= 0;
    end
    repeat (30) @(posedge mclk_i);
  endtask
  task t_regs;
    rd(A_C); chk("ctrl reset", 0, rd_d);
    rd(A_H); chk("high reset", 0, rd_d);
    rd(A_L); chk("low reset", 0, rd_d);
    rd(32'h3ff00); chk("unmapped resp", 2, rd_r);
    wr(32'h3ff00, 8'h55); chk("unmapped bresp", 2, wr_r);
    wr(A_L, 8'h5a); chk("low bresp", 0, wr_r);
    s_axi_wstrb_i <= 4'h0;
    wr(A_H, 8'h55);
    s_axi_wstrb_i <= 4'h1;
    rd(A_H); chk("masked write", 0, rd_d);
    rd(A_L); chk("low write", 8'h5a, rd_d);
    wr(A_C, 8'hff); rd(A_C); chk("ctrl", 8'hcf, rd_d);
    chk("endpoint", 7, ubm_endpoint_select_o);
    chk("direction", 1, ubm_endpoint_direction_o);
    chk("wrap", 1, ubm_wrap_buffer_enable_o);
    wr(A_C, 8'h09);
  endtask
  task t_off;
    wr(A_L, 8'hff); wr(A_H, 8'h3f); frame;
    chk("bytes when off", 0, nb);
  endtask
  task t_in;
    for (b = 0; b < 4; b = b + 1) begin
      wr(A_L, 8'h05); wr(A_H, {b[1:0], 6'h0}); rd(A_H);
      chk("high", {b[1:0], 6'h0}, rd_d);
      wr(A_C, 8'h89);
      slow <= (b == 3); frame;
      chk("in count", 2 * (b + 1), nb);
      chk("in last lane", 8'h11 * (b + 1), seen[b]);
      chk("in second slot", 8'h11, seen[b + 1]);
      wr(A_C, 8'h09);
    end
  endtask
  task t_out;
    wr(A_L, 8'h00); wr(A_H, 8'he0); wr(A_C, 8'h82); frame;
    chk("tx count", 1, ntx);
    chk("tx slot", 13, txs);
    chk("tx word", 32'h59585b5a, txw);
    rd(A_S); chk("status", 8'h0d, rd_d);
    wr(A_C, 8'h42); wr(A_C, 8'hc2); frame;
    chk("wrap word", 32'h5d5c5f5e, txw);
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1;
    t_regs; t_off; t_in; t_out;
    end_sim;
  end
  initial begin
    #400000;
    err_count = err_count + 1;
    end_sim;
  end
endmodule // csd_dma_channel_bench

//--- bench/csd_dma_chk.sv
// port assertions of the codec slot dma channel
`timescale 1ns/1ns
module csd_dma_chk (
  // clock and reset
  input wire mclk_i, rst_n_i,
  // register bus
  input wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i,
  input wire s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
  input wire [31:0] s_axi_rdata_o,
  // codec port and buffer manager
  input wire cpi_frame_start_i, cpi_slot_tick_i, cpi_tx_we_o,
  input wire ubm_req_o, ubm_ack_i, ubm_endpoint_direction_o,
  input wire [7:0] ubm_offset_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wr_done_a:
    assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o) else $error("write end");
  rd_done_a:
    assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o) else $error("read end");
  wr_block_a:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o) else $error("write overlap");
  rd_upper_a:
    assert property (s_axi_rvalid_o |-> !s_axi_arready_o && s_axi_rdata_o[31:8] == 24'h0) else $error("read data");
  tx_pulse_a:
    assert property (cpi_tx_we_o |=> !cpi_tx_we_o) else $error("tx strobe long");
  tx_dir_a:
    assert property (cpi_tx_we_o |-> !ubm_endpoint_direction_o) else $error("tx in wrong direction");
  byte_step_a:
    assert property (ubm_req_o && ubm_ack_i && !cpi_frame_start_i |=> ubm_offset_o == $past(ubm_offset_o) + 8'h01)
      else $error("offset step");
  req_cause_a:
    assert property ($rose(ubm_req_o) |-> $past(cpi_frame_start_i || cpi_slot_tick_i, 2)) else $error("req cause");
endmodule // csd_dma_chk
bind csd_dma_channel csd_dma_chk csd_dma_chk_inst (.*);

//--- bench/csd_ubm_model.sv
// buffer manager model: acks bytes promptly or slowly
`timescale 1ns/1ns
module csd_ubm_model (
  input wire mclk_i,
  input wire rst_n_i,
  input wire slow_i,
  input wire req_i,
  input wire [7:0] offset_i,
  output reg ack_o,
  output wire [7:0] rdata_o
);
  reg [1:0] cnt_q;
  // byte valid only with ack, else a moving pattern
  assign rdata_o = ack_o ? offset_i ^ 8'h5a : ~(offset_i ^ 8'h5a);
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      ack_o <= req_i & ~ack_o & (~slow_i | cnt_q == 2'h3);
    end
  end
endmodule // csd_ubm_model

//--- core/csd_dma_channel.v
// codec slot dma channel: registers over axi4-lite and the byte mover
// How it works
// - three registers per channel, consecutive ascending, plus status
// - move data only for selected slots
// - fourteen slot bits across low/high register
// - high bits 7:6 give one to four bytes
// - control bit 3 picks IN or OUT
// - control bit 7 enables the channel
// - bit 6 enables wrap, channel and manager
// - control bits 2:0 select endpoint
// - control bits 5:4 read zero
`timescale 1ns/1ns
`include "csd_defines.vh"

module csd_dma_channel (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // codec port frame timing
  input wire cpi_frame_start_i,
  input wire cpi_slot_tick_i,
  // codec port data registers
  input wire [31:0] cpi_rx_word_i,
  output reg [31:0] cpi_tx_word_o,
  output reg [3:0] cpi_tx_slot_o,
  output reg cpi_tx_we_o,
  // usb buffer manager byte port
  output reg ubm_req_o,
  input wire ubm_ack_i,
  output reg [7:0] ubm_wdata_o,
  input wire [7:0] ubm_rdata_i,
  output reg [7:0] ubm_offset_o,
  // usb buffer manager configuration
  output reg [2:0] ubm_endpoint_select_o,
  output reg ubm_endpoint_direction_o,
  output reg ubm_wrap_buffer_enable_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_XFER = 1'b1;

  // registers
  reg [7:0] ctrl_q;
  reg [7:0] ssh_q;
  reg [7:0] ssl_q;
  reg ovr_q;

  // axi state
  reg [31:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  // mover state
  reg state_q;
  reg [1:0] cnt_q;
  reg [31:0] word_q;
  reg [3:0] slot_q;

  // decoded fields
  wire channel_enable;
  wire wrap_buffer_enable;
  wire endpoint_direction;
  wire [2:0] endpoint_select;
  wire [1:0] bytes_per_slot;
  wire [13:0] slot_select_bits;
  wire hit;
  wire [3:0] hit_slot;

  assign channel_enable = ctrl_q[`CSD_CTRL_EN];
  assign wrap_buffer_enable = ctrl_q[`CSD_CTRL_WRAP];
  assign endpoint_direction = ctrl_q[`CSD_CTRL_DIR];
  assign endpoint_select = ctrl_q[`CSD_CTRL_EP_HI:`CSD_CTRL_EP_LO];
  assign bytes_per_slot = ssh_q[`CSD_SSH_BPS_HI:`CSD_SSH_BPS_LO];
  assign slot_select_bits = {ssh_q[`CSD_SSH_SLOT_HI:`CSD_SSH_SLOT_LO], ssl_q};

  // slot sequencing
  csd_slot_seq u_seq (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .frame_start_i(cpi_frame_start_i),
    .slot_tick_i(cpi_slot_tick_i),
    .enable_i(channel_enable),
    .slot_sel_i(slot_select_bits),
    .hit_o(hit),
    .hit_slot_o(hit_slot)
  );

  // write decode
  wire wr_go;
  wire wr_ctrl;
  wire wr_ssh;
  wire wr_ssl;
  wire wr_stat;
  wire wr_hit;

  assign wr_go = ~s_axi_awready_o & ~s_axi_wready_o & ~s_axi_bvalid_o;
  assign wr_ctrl = awaddr_q[31:2] == {14'h0000, `CSD_IDX_CTRL};
  assign wr_ssh = awaddr_q[31:2] == {14'h0000, `CSD_IDX_SSH};
  assign wr_ssl = awaddr_q[31:2] == {14'h0000, `CSD_IDX_SSL};
  assign wr_stat = awaddr_q[31:2] == {14'h0000, `CSD_IDX_STAT};
  assign wr_hit = wr_ctrl | wr_ssh | wr_ssl | wr_stat;

  // read decode
  reg [7:0] rd_byte;
  reg rd_hit;

  always @* begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (s_axi_araddr_i[31:2])
      {14'h0000, `CSD_IDX_CTRL}: begin
        rd_byte = ctrl_q & `CSD_CTRL_RSV_MASK;
      end
      {14'h0000, `CSD_IDX_SSH}: begin
        rd_byte = ssh_q;
      end
      {14'h0000, `CSD_IDX_SSL}: begin
        rd_byte = ssl_q;
      end
      {14'h0000, `CSD_IDX_STAT}: begin
        rd_byte = {state_q, ovr_q, 2'b00, slot_q};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // axi write channels
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `CSD_RESP_OKAY;
      awaddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        awaddr_q <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? `CSD_RESP_OKAY : `CSD_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // axi read channels
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `CSD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {24'h000000, rd_byte};
        s_axi_rresp_o <= rd_hit ? `CSD_RESP_OKAY : `CSD_RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // register file
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `CSD_RST_CTRL;
      ssh_q <= `CSD_RST_SSH;
      ssl_q <= `CSD_RST_SSL;
    end else if (wr_go && wstrb_q[0]) begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[7:0] & `CSD_CTRL_RSV_MASK;
      end
      if (wr_ssh) begin
        ssh_q <= wdata_q[7:0];
      end
      if (wr_ssl) begin
        ssl_q <= wdata_q[7:0];
      end
    end
  end

  // configuration towards the buffer manager
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ubm_endpoint_select_o <= 3'h0;
      ubm_endpoint_direction_o <= 1'b0;
      ubm_wrap_buffer_enable_o <= 1'b0;
    end else begin
      ubm_endpoint_select_o <= endpoint_select;
      ubm_endpoint_direction_o <= endpoint_direction;
      ubm_wrap_buffer_enable_o <= wrap_buffer_enable;
    end
  end

  // byte mover next values
  wire last_byte;
  wire ack_take;
  reg [31:0] tx_next;

  assign last_byte = cnt_q == bytes_per_slot;
  assign ack_take = (state_q == ST_XFER) && ubm_ack_i && channel_enable;

  always @* begin
    tx_next = word_q;
    tx_next[cnt_q*8 +: 8] = ubm_rdata_i;
  end

  // byte mover
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 2'h0;
      word_q <= 32'h00000000;
      slot_q <= 4'h0;
      ovr_q <= 1'b0;
      ubm_req_o <= 1'b0;
      ubm_wdata_o <= 8'h00;
      ubm_offset_o <= 8'h00;
      cpi_tx_word_o <= 32'h00000000;
      cpi_tx_slot_o <= 4'h0;
      cpi_tx_we_o <= 1'b0;
    end else begin
      cpi_tx_we_o <= 1'b0;
      if (wr_go && wr_stat && wstrb_q[0] && wdata_q[`CSD_STAT_OVR] && !(hit && state_q == ST_XFER)) begin
        ovr_q <= 1'b0;
      end
      if (cpi_frame_start_i && !wrap_buffer_enable) begin
        ubm_offset_o <= 8'h00;
      end
      case (state_q)
        ST_IDLE: begin
          if (hit && channel_enable) begin
            state_q <= ST_XFER;
            cnt_q <= 2'h0;
            slot_q <= hit_slot;
            word_q <= cpi_rx_word_i;
            ubm_wdata_o <= cpi_rx_word_i[7:0];
            ubm_req_o <= 1'b1;
          end
        end
        ST_XFER: begin
          if (!channel_enable) begin
            state_q <= ST_IDLE;
            ubm_req_o <= 1'b0;
            if (ubm_ack_i) begin
              ubm_offset_o <= ubm_offset_o + 8'h01;
            end
          end else begin
            if (hit) begin
              ovr_q <= 1'b1;
            end
            if (ack_take) begin
              ubm_offset_o <= ubm_offset_o + 8'h01;
              if (!endpoint_direction) begin
                word_q <= tx_next;
              end
              if (last_byte) begin
                state_q <= ST_IDLE;
                ubm_req_o <= 1'b0;
                if (!endpoint_direction) begin
                  cpi_tx_word_o <= tx_next;
                  cpi_tx_slot_o <= slot_q;
                  cpi_tx_we_o <= 1'b1;
                end
              end else begin
                cnt_q <= cnt_q + 2'h1;
                ubm_wdata_o <= word_q[(cnt_q + 2'h1)*8 +: 8];
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          ubm_req_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // csd_dma_channel

//--- core/csd_slot_seq.v
// codec slot sequencer: tracks slot number and flags selected slots
`timescale 1ns/1ns
`include "csd_defines.vh"

module csd_slot_seq (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // codec frame timing
  input wire frame_start_i,
  input wire slot_tick_i,
  // configuration
  input wire enable_i,
  input wire [13:0] slot_sel_i,
  // selected slot event
  output reg hit_o,
  output reg [3:0] hit_slot_o
);

  reg [3:0] slot_q;
  reg past_q;
  reg [3:0] slot_d;
  reg past_d;
  reg sel_d;

  // slot number counts upward from the frame start
  always @* begin
    slot_d = slot_q;
    past_d = past_q;
    if (frame_start_i) begin
      slot_d = 4'h0;
      past_d = 1'b0;
    end else if (slot_tick_i) begin
      if (slot_q == `CSD_LAST_SLOT) begin
        past_d = 1'b1;
      end else begin
        slot_d = slot_q + 4'h1;
      end
    end
    sel_d = (frame_start_i | (slot_tick_i & ~past_d)) & slot_sel_i[slot_d] & enable_i;
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_q <= 4'h0;
      past_q <= 1'b1;
      hit_o <= 1'b0;
      hit_slot_o <= 4'h0;
    end else begin
      slot_q <= slot_d;
      past_q <= past_d;
      hit_o <= sel_d;
      hit_slot_o <= slot_d;
    end
  end

endmodule // csd_slot_seq

//--- shared/csd_defines.vh
// register map, field layout and reset values of the codec slot dma channel
`ifndef CSD_DEFINES_VH
`define CSD_DEFINES_VH

// register indices, byte address is four times the index
`define CSD_IDX_CTRL 16'hfff7
`define CSD_IDX_SSH 16'hfff8
`define CSD_IDX_SSL 16'hfff9
`define CSD_IDX_STAT 16'hfff0

// reset values
`define CSD_RST_CTRL 8'h00
`define CSD_RST_SSH 8'h00
`define CSD_RST_SSL 8'h00

// control register fields
`define CSD_CTRL_EN 7
`define CSD_CTRL_WRAP 6
`define CSD_CTRL_RSV_MASK 8'hcf
`define CSD_CTRL_DIR 3
`define CSD_CTRL_EP_HI 2
`define CSD_CTRL_EP_LO 0

// slot select high register fields
`define CSD_SSH_BPS_HI 7
`define CSD_SSH_BPS_LO 6
`define CSD_SSH_SLOT_HI 5
`define CSD_SSH_SLOT_LO 0

// status register fields
`define CSD_STAT_BUSY 7
`define CSD_STAT_OVR 6
`define CSD_STAT_SLOT_HI 3
`define CSD_STAT_SLOT_LO 0

// slot geometry
`define CSD_NUM_SLOTS 14
`define CSD_LAST_SLOT 4'hd

// axi responses
`define CSD_RESP_OKAY 2'b00
`define CSD_RESP_SLVERR 2'b10

`endif
